// File: pkg/sadc_map.vh
// Constants for the serial readout and power-mode block
// Function
// - Rise between edges 2-10: partial power-down
// - From partial, rise before 10: full down
// - No glitch filter on full power-down path
// - Dummy cycle past edge 10 wakes
// - One dummy cycle wakes from partial
// - Hold during partial wake, track after edge
// - Select fall: hold, drive; sample and start in normal mode only
// - 12-bit: 14 clocks, track after 13
// - 12-bit frame ends two zeros, off at 16
// - 10-bit: 12 clocks, four trailing zeros
// - 8-bit: 10 clocks, six trailing zeros
// - Rise after edge 14 drops trailing zeros
// - Select fall gives first leading zero
// - Late select fall still shows zero
// - Rise before edge 2 keeps normal mode
// - Rise edges 10-16 aborts, stays powered
`ifndef SADC_MAP_VH
`define SADC_MAP_VH
`define SADC_MODE_NORMAL 3'h1
`define SADC_MODE_PARTIAL 3'h2
`define SADC_MODE_FULL 3'h4
`define SADC_GLITCH_EDGES 5'h02
`define SADC_POWER_EDGES 5'h0a
`define SADC_FRAME_EDGES 5'h10
`define SADC_LEAD_ZEROS 5'h02
`define SADC_FIFO_DEPTH 8
`define SADC_WAKE_NS 1000
`define SADC_CLK_NS 10
`define SADC_WAKE_CYC ((`SADC_WAKE_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`endif

// File: hw/sadc_sync.v
// Two-flop synchroniser with edge detection on the second stage output
module sadc_sync (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire din,
  input wire init,
  output reg dout,
  output wire rise,
  output wire fall
);
  reg meta;
  reg last;
  always @(posedge ref_clk) begin
    if (rst) begin
      meta <= 1'b0;
      dout <= 1'b0;
      last <= 1'b0;
    end else if (clk_en) begin
      meta <= din;
      dout <= meta;
      last <= dout;
    end
  end
  // Init only matters in the first cycles; reset constant is low, not the idle-high level of the pins
  assign rise = clk_en & dout & ~last & ~init;
  assign fall = clk_en & ~dout & last & ~init;
endmodule // sadc_sync

// File: hw/sadc_fifo.v
// Result FIFO between the converter core and the serial shifter
module sadc_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign do_wr = clk_en & in_valid & in_ready;
  assign do_rd = clk_en & out_valid & out_ready;
  always @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
  always @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @* begin
    out_data = mem[rd_ptr];
  end
endmodule // sadc_fifo

// File: hw/sadc_core.v
// Serial readout and power-mode control of a SAR converter
`include "sadc_map.vh"
module sadc_core #(
  parameter RES = 12,
  parameter WAKE_CYC = `SADC_WAKE_CYC
) (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire cs_n,
  input wire sclk,
  input wire sample_valid,
  output wire sample_ready,
  input wire [RES-1:0] sample_data,
  output reg ser_dout,
  output reg ser_dout_oe,
  output reg track,
  output reg conv_start,
  output reg [2:0] power_mode,
  output reg analog_on,
  output reg powered
);
  localparam ST_IDLE = 3'h1;
  localparam ST_FRAME = 3'h2;
  localparam ST_DONE = 3'h4;
  localparam [4:0] CONV_EDGES = RES + 2;
  localparam [4:0] TRACK_EDGES = RES + 1;
  localparam [15:0] WAKE_LIM = WAKE_CYC;

  wire cs_s;
  wire cs_rise;
  wire cs_fall;
  wire sclk_s;
  wire sclk_rise;
  wire sclk_fall;
  reg [2:0] state;
  reg [4:0] edges;
  reg [15:0] frame;
  reg [RES-1:0] result;
  reg waking;
  reg hold_wake;
  reg [15:0] wake_cnt;
  reg init;
  reg [1:0] init_cnt;
  wire fifo_valid;
  wire [RES-1:0] fifo_data;
  reg fifo_take;

  // Select idles high; init masks the reset-time rising edge
  sadc_sync u_cs (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .din(cs_n),
    .init(init),
    .dout(cs_s),
    .rise(cs_rise),
    .fall(cs_fall)
  );
  sadc_sync u_sclk (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .din(sclk),
    .init(init),
    .dout(sclk_s),
    .rise(sclk_rise),
    .fall(sclk_fall)
  );
  sadc_fifo #(
    .WIDTH(RES),
    .DEPTH(`SADC_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  // Frame word: two zeros, result MSB first, zero fill
  function [15:0] build_frame;
    input [RES-1:0] res;
    begin
      build_frame = 16'h0000;
      build_frame[15-`SADC_LEAD_ZEROS -: RES] = res;
    end
  endfunction

  always @* begin
    fifo_take = 1'b0;
    if (cs_fall && state != ST_FRAME && power_mode == `SADC_MODE_NORMAL) begin
      fifo_take = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      edges <= 5'h00;
      frame <= 16'h0000;
      result <= {RES{1'b0}};
      ser_dout <= 1'b0;
      ser_dout_oe <= 1'b0;
      track <= 1'b1;
      conv_start <= 1'b0;
      power_mode <= `SADC_MODE_NORMAL;
      analog_on <= 1'b1;
      powered <= 1'b1;
      waking <= 1'b0;
      hold_wake <= 1'b0;
      wake_cnt <= 16'h0000;
      init <= 1'b1;
      init_cnt <= 2'h3;
    end else if (clk_en) begin
      // Syncs reset low while the pins idle high; mask the false rise that follows
      if (init_cnt != 2'h0) begin
        init_cnt <= init_cnt - 2'h1;
      end
      init <= (init_cnt > 2'h1);
      conv_start <= 1'b0;
      if (wake_cnt != 16'h0000) begin
        wake_cnt <= wake_cnt - 16'h0001;
        if (wake_cnt == 16'h0001) begin
          powered <= 1'b1;
        end
      end
      case (state)
        ST_IDLE, ST_DONE: begin
          if (cs_fall) begin
            // Hold, drive first leading zero; sample and start in normal mode only
            state <= ST_FRAME;
            edges <= 5'h00;
            ser_dout <= 1'b0;
            ser_dout_oe <= 1'b1;
            conv_start <= (power_mode == `SADC_MODE_NORMAL);
            if (power_mode == `SADC_MODE_NORMAL) begin
              track <= 1'b0;
              result <= fifo_valid ? fifo_data : {RES{1'b0}};
              frame <= build_frame(fifo_valid ? fifo_data : {RES{1'b0}});
              waking <= 1'b0;
            end else begin
              frame <= 16'h0000;
              waking <= 1'b1;
              hold_wake <= (power_mode == `SADC_MODE_PARTIAL);
              analog_on <= 1'b1;
              track <= 1'b0;
            end
          end
        end
        ST_FRAME: begin
          if (hold_wake && (sclk_rise || sclk_fall)) begin
            track <= 1'b1;
            hold_wake <= 1'b0;
          end
          if (sclk_fall && !cs_rise) begin
            edges <= edges + 5'h01;
            frame <= {frame[14:0], 1'b0};
            ser_dout <= frame[14];
            if (edges + 5'h01 == `SADC_FRAME_EDGES) begin
              ser_dout_oe <= 1'b0;
              ser_dout <= 1'b0;
              state <= ST_DONE;
            end
            if (edges + 5'h01 == `SADC_POWER_EDGES && waking) begin
              // Staying low past edge 10 completes the wake
              waking <= 1'b0;
              power_mode <= `SADC_MODE_NORMAL;
              if (power_mode == `SADC_MODE_FULL) begin
                wake_cnt <= WAKE_LIM;
              end else begin
                powered <= 1'b1;
              end
            end
          end
          if (sclk_rise && !waking && edges == TRACK_EDGES) begin
            track <= 1'b1;
          end
          if (cs_rise) begin
            // Any select rise ends the frame; no further clocks needed
            state <= ST_IDLE;
            ser_dout_oe <= 1'b0;
            ser_dout <= 1'b0;
            track <= 1'b1;
            hold_wake <= 1'b0;
            if (edges < `SADC_POWER_EDGES) begin
              if (power_mode != `SADC_MODE_NORMAL) begin
                // No glitch filter on the path from partial
                power_mode <= `SADC_MODE_FULL;
                analog_on <= 1'b0;
                powered <= 1'b0;
                waking <= 1'b0;
                wake_cnt <= 16'h0000;
              end else if (edges >= `SADC_GLITCH_EDGES) begin
                power_mode <= `SADC_MODE_PARTIAL;
                analog_on <= 1'b1;
                powered <= 1'b0;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // sadc_core

// File: tb/sadc_core_properties.sv
// Port-level assertions for the serial readout and power-mode core
module sadc_core_properties (
  input wire ref_clk,
  input wire rst,
  input wire cs_n,
  input wire ser_dout,
  input wire ser_dout_oe,
  input wire track,
  input wire conv_start,
  input wire [2:0] power_mode,
  input wire analog_on,
  input wire powered
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_mode_onehot; $onehot(power_mode); endproperty
  a_mode_onehot: assert property (p_mode_onehot)
    else $error("power mode not one-hot");
  // Wake frames power up from select fall, so only the idle full mode is dark
  property p_full_dark; power_mode == 3'h4 && !ser_dout_oe |-> !analog_on; endproperty
  a_full_dark: assert property (p_full_dark)
    else $error("analog on in full power-down");
  property p_start_drive; conv_start |=> (ser_dout_oe && !track) [*4]; endproperty
  a_start_drive: assert property (p_start_drive)
    else $error("no drive or hold after start");
  property p_lead_zero; conv_start |-> !ser_dout ##1 !ser_dout; endproperty
  a_lead_zero: assert property (p_lead_zero)
    else $error("first leading bit not zero");
  property p_partial_src; $rose(power_mode[1]) |-> $past(power_mode[0]); endproperty
  a_partial_src: assert property (p_partial_src)
    else $error("partial entered not from normal");
  property p_full_src; $rose(power_mode[2]) |-> !$past(power_mode[0]); endproperty
  a_full_src: assert property (p_full_src)
    else $error("full entered from normal");
  // Sync delay is two cycles, so eight idle cycles leave margin
  property p_idle_off; cs_n [*8] |-> !ser_dout_oe; endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("output driven while deselected");
  property p_pwr_norm; powered |-> power_mode == 3'h1; endproperty
  a_pwr_norm: assert property (p_pwr_norm)
    else $error("powered outside normal mode");
  c_partial: cover property ($rose(power_mode[1]));
  c_full: cover property ($rose(power_mode[2]));
  c_start: cover property (conv_start);
endmodule // sadc_core_properties

bind sadc_core sadc_core_properties u_chk (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
  .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe), .track(track), .conv_start(conv_start),
  .power_mode(power_mode), .analog_on(analog_on), .powered(powered));

// File: tb/sadc_host.sv
// Host model driving select and an 80 ns serial clock
module sadc_host (
  input wire ref_clk,
  input wire ser_dout,
  output logic cs_n,
  output logic sclk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Serial clock idles high and stands still outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Bits are sampled just before each fall, when the last shift has settled
  task automatic frame(input int n, output logic [15:0] b);
    b = 16'h0000;
    wait_cyc(1);
    cs_n = 1'b0;
    wait_cyc(8);
    for (int i = 0; i < n; i++) begin
      b = {b[14:0], ser_dout};
      sclk = 1'b0;
      wait_cyc(4);
      sclk = 1'b1;
      wait_cyc(4);
    end
    cs_n = 1'b1;
    // Full 16-clock frames run near 670 kSPS, above the 600 kSPS where power-down still pays
    wait_cyc(12);
  endtask
endmodule // sadc_host

// File: tb/sadc_core_tb.sv
// Self-checking bench for the serial readout and power-mode core
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module sadc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, sample_valid, clk_en;
  logic [11:0] sample_data;
  logic [15:0] bits;
  wire cs_n, sclk, sample_ready, ser_dout, ser_dout_oe, track, conv_start, analog_on, powered;
  wire [2:0] power_mode;
  int fail_count = 0;
  int check_count = 0;
  int starts = 0;
  // Short wake count keeps the run brief
  sadc_core #(.RES(12), .WAKE_CYC(5)) dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .cs_n(cs_n), .sclk(sclk), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe), .track(track),
    .conv_start(conv_start), .power_mode(power_mode), .analog_on(analog_on), .powered(powered));
  sadc_host u_host (.ref_clk(ref_clk), .ser_dout(ser_dout), .cs_n(cs_n), .sclk(sclk));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (conv_start === 1'b1) starts++;
  task automatic end_sim;
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic run(input int n, input logic [2:0] m);
    u_host.frame(n, bits);
    `CHK("power_mode", m, power_mode)
    `CHK("ser_dout_oe", 1'b0, ser_dout_oe)
  endtask
  task automatic t_reset;
    `CHK("track", 1'b1, track)
    `CHK("power_mode", 3'h1, power_mode)
    `CHK("powered", 1'b1, powered)
    run(16, 3'h1);
    `CHK("dummy", 16'h0000, bits)
  endtask
  task automatic t_fill;
    for (int i = 0; i < 8; i++) begin
      sample_valid = 1'b1;
      sample_data = 12'ha5c ^ 12'(i);
      u_host.wait_cyc(1);
    end
    sample_valid = 1'b0;
    `CHK("sample_ready", 1'b0, sample_ready)
  endtask
  task automatic t_frame;
    int s;
    s = starts;
    run(16, 3'h1);
    `CHK("frame", {2'b00, 12'ha5c, 2'b00}, bits)
    `CHK("conv_start", s + 1, starts)
    `CHK("track", 1'b1, track)
  endtask
  task automatic t_power;
    run(1, 3'h1);
    run(5, 3'h2);
    `CHK("analog_on", 1'b1, analog_on)
    run(1, 3'h4);
    `CHK("analog_on", 1'b0, analog_on)
    run(16, 3'h1);
    u_host.wait_cyc(7);
    `CHK("powered", 1'b1, powered)
  endtask
  task automatic t_partial_wake;
    run(5, 3'h2);
    run(16, 3'h1);
    `CHK("powered", 1'b1, powered)
  endtask
  task automatic t_abort;
    run(12, 3'h1);
    run(14, 3'h1);
    `CHK("frame14", {4'h0, 12'ha59}, bits)
  endtask
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    sample_valid = 1'b0;
    sample_data = 12'h000;
    repeat (8) @(posedge ref_clk);
    #1 rst = 1'b0;
    u_host.wait_cyc(2);
    t_reset();
    t_fill();
    t_frame();
    t_power();
    t_partial_wake();
    t_abort();
    end_sim();
  end
  initial begin
    #500us;
    fail_count++;
    end_sim();
  end
endmodule // sadc_core_tb
